// [design/gp_cfg_pkg.sv]
package gp_cfg_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [7:0] CFG_ADR      = 8'h00;
  localparam logic [7:0] PA_OUT_ADR   = 8'h04;
  localparam logic [7:0] PA_IN_ADR    = 8'h08;
  localparam logic [7:0] PB_ADR       = 8'h0c;
  localparam logic [7:0] DIFF_ADR     = 8'h10;
  localparam logic [7:0] STAT_ADR     = 8'h14;
  localparam logic [7:0] BV_ADR       = 8'h18;
  // configuration register bit positions
  localparam int CFG_PA_OE   = 0;
  localparam int CFG_DIFF    = 1;
  localparam int CFG_PB_OE   = 2;
  localparam int CFG_MEM16   = 3;
  localparam int CFG_ODD     = 4;
  localparam int CFG_W       = 5;
  // status register bit positions
  localparam int ST_REQ      = 0;
  localparam int ST_BUSY     = 1;
  localparam int ST_PERR     = 2;
  localparam int ST_LVL      = 4;
  // first-port bits that become byte-valid strobes
  localparam int LOW_VALID_BIT  = 2;
  localparam int HIGH_VALID_BIT = 7;
  // reset values
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [1:0] BV_RST        = 2'h0;
  // handshake timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int HS_PERIOD_NS  = 100;
  localparam int HS_MIN_CYC    = (HS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH    = 8;
endpackage

// [design/buf_hs_if.sv]
`timescale 1ns/10ps
// carries the buffer handshake between the port logic and its engine
interface buf_hs_if;
  logic       mem16;
  logic       to_mem;
  logic       active;
  logic       odd_start;
  logic       last_one;
  logic [3:0] level;
  logic       ack_n;
  logic       req;
  logic       busy;
  logic       done;
  logic [1:0] bv;
  modport engine (input mem16, to_mem, active, odd_start, last_one, level, ack_n,
                  output req, busy, done, bv);
  modport ctrl   (output mem16, to_mem, active, odd_start, last_one, level, ack_n,
                  input req, busy, done, bv);
endinterface

// [design/buf_hs_engine.sv]
`timescale 1ns/10ps
// request/acknowledge engine for the buffer memory bus
module buf_hs_engine (
  input  wire logic clk_i,
  input  wire logic rst_i,
  buf_hs_if.engine  hs
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    REQ  = 3'b010,
    HOLD = 3'b100
  } hs_state_t;

  hs_state_t   state_r;
  hs_state_t   state_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        req_r;
  logic        done_r;
  logic [1:0]  bv_r;
  logic [1:0]  bv_nxt;

  // bytes needed for the next handshake and the strobe pattern it carries
  wire         single  = !hs.mem16 || hs.odd_start || hs.last_one;
  wire  [3:0]  need    = single ? 4'h1 : 4'h2;
  wire  [3:0]  space   = 4'(gp_cfg_pkg::FIFO_DEPTH) - hs.level;
  wire         ready   = hs.to_mem ? (hs.level >= need) : (space >= need);
  // odd start puts the byte on the high lane, a trailing odd byte on the low lane
  assign bv_nxt = !hs.mem16 ? 2'h1 : hs.odd_start ? 2'h2 : hs.last_one ? 2'h1 : 2'h3;
  // rise-to-rise spacing is counted from the last request edge
  wire         spaced  = cnt_r >= 3'(gp_cfg_pkg::HS_MIN_CYC - 1);
  wire         start   = (state_r == IDLE) && hs.active && ready && spaced;

  // next state: request drops once the acknowledge falls
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE: if (start) state_nxt = REQ;
      REQ:  if (!hs.ack_n) state_nxt = HOLD;
      HOLD: if (hs.ack_n) state_nxt = IDLE;
    endcase
  end

  // saturating spacing counter, cleared at each request edge
  assign cnt_nxt = start ? 3'h0 : (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= IDLE;
      cnt_r   <= 3'h7;
      req_r   <= 1'b0;
      done_r  <= 1'b0;
      bv_r    <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      req_r   <= (state_nxt == REQ);
      done_r  <= (state_r == REQ) && !hs.ack_n;
      if (start) bv_r <= bv_nxt;
    end
  end

  assign hs.req  = req_r;
  assign hs.busy = (state_r != IDLE);
  assign hs.done = done_r;
  assign hs.bv   = bv_r;
endmodule

// [design/dual_gp_port_config.sv]
`timescale 1ns/10ps
// two general-purpose ports with differential, strobe and high-byte modes
module dual_gp_port_config (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // first port pins
  input  wire logic [7:0]  port_a_i,
  output logic      [7:0]  port_a_o,
  output logic      [7:0]  port_a_oe_o,
  // second port pins and its parity pin
  input  wire logic [7:0]  port_b_i,
  output logic      [7:0]  port_b_o,
  output logic      [7:0]  port_b_oe_o,
  input  wire logic        hi_parity_i,
  output logic             hi_parity_o,
  output logic             hi_parity_oe_o,
  // buffer handshake pins
  output logic             buffer_request_o,
  input  wire logic        buffer_ack_n_i,
  // dma and fifo side, same clock
  input  wire logic        dma_active_i,
  input  wire logic        to_mem_i,
  input  wire logic        last_byte_i,
  input  wire logic [3:0]  fifo_level_i,
  input  wire logic [7:0]  fifo_hi_data_i,
  output logic             xfer_o,
  output logic      [1:0]  xfer_bytes_o,
  output logic      [7:0]  mem_hi_data_o
);
  buf_hs_if hs ();

  // software state
  logic [gp_cfg_pkg::CFG_W-1:0] cfg_r;
  logic [7:0]  first_port_output_reg_r;
  logic [7:0]  pb_out_r;
  logic [7:0]  diff_ctrl_r;
  logic [1:0]  bv_ctrl_r;
  logic        perr_r;
  // pin synchronisers
  logic [7:0]  pa_s1_r;
  logic [7:0]  pa_s2_r;
  logic [7:0]  pb_s1_r;
  logic [7:0]  pb_s2_r;
  logic        par_s1_r;
  logic        par_s2_r;
  logic        ack_s1_r;
  logic        ack_s2_r;
  // pin and bus output flops
  logic [7:0]  pa_o_r;
  logic [7:0]  pa_oe_r;
  logic [7:0]  pa_o_nxt;
  logic [7:0]  pa_oe_nxt;
  logic [7:0]  pb_o_r;
  logic [7:0]  pb_oe_r;
  logic        par_o_r;
  logic        par_oe_r;
  logic        req_pin_r;
  logic        xfer_r;
  logic [1:0]  xfer_bytes_r;
  logic [7:0]  mem_hi_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        ack_r;

  // configuration fields
  wire         pa_oe    = cfg_r[gp_cfg_pkg::CFG_PA_OE];
  wire         diff_en  = cfg_r[gp_cfg_pkg::CFG_DIFF];
  wire         pb_oe    = cfg_r[gp_cfg_pkg::CFG_PB_OE];
  wire         mem16    = cfg_r[gp_cfg_pkg::CFG_MEM16];
  wire         odd_st   = cfg_r[gp_cfg_pkg::CFG_ODD];

  // bus decode; a write commits in the cycle the ack is raised
  wire         wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
  wire         wr       = wb_req && wb_we_i && wb_sel_i[0];
  wire         wr_cfg   = wr && (wb_adr_i == gp_cfg_pkg::CFG_ADR);
  wire         wr_pa    = wr && (wb_adr_i == gp_cfg_pkg::PA_OUT_ADR);
  wire         wr_pb    = wr && (wb_adr_i == gp_cfg_pkg::PB_ADR);
  wire         wr_diff  = wr && (wb_adr_i == gp_cfg_pkg::DIFF_ADR);
  wire         wr_stat  = wr && (wb_adr_i == gp_cfg_pkg::STAT_ADR);
  wire         wr_bv    = wr && (wb_adr_i == gp_cfg_pkg::BV_ADR);

  // handshake engine hookup
  assign hs.mem16     = mem16;
  assign hs.to_mem    = to_mem_i;
  assign hs.active    = dma_active_i;
  assign hs.odd_start = odd_st;
  assign hs.last_one  = last_byte_i;
  assign hs.level     = fifo_level_i;
  assign hs.ack_n     = ack_s2_r;

  buf_hs_engine u_engine (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .hs    (hs)
  );

  // strobes come from the engine during a handshake, else from software
  wire  [1:0]  bv_act        = hs.busy ? hs.bv : bv_ctrl_r;
  wire         low_byte_valid_n  = ~bv_act[0];
  wire         high_byte_valid_n = ~bv_act[1];

  // first port, per bit: strobe, differential control or plain output
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pa
      localparam bit STROBE_BIT = (i == gp_cfg_pkg::LOW_VALID_BIT) || (i == gp_cfg_pkg::HIGH_VALID_BIT);
      wire is_bv   = mem16 && STROBE_BIT;
      wire is_diff = diff_en && !STROBE_BIT;
      wire strobe  = (i == gp_cfg_pkg::LOW_VALID_BIT) ? low_byte_valid_n : high_byte_valid_n;
      // differential wins over the port enable; all clear leaves the pin floating
      assign pa_oe_nxt[i] = is_bv || is_diff || pa_oe;
      assign pa_o_nxt[i]  = is_bv ? strobe :
                            is_diff ? ~diff_ctrl_r[i] :
                            ~first_port_output_reg_r[i];
    end
  endgenerate

  // second port: memory high byte beats general output
  wire         pb_mem_drv = mem16 && to_mem_i && hs.busy;
  wire         pb_oe_nxt  = mem16 ? pb_mem_drv : pb_oe;
  wire  [7:0]  pb_o_nxt   = mem16 ? fifo_hi_data_i : pb_out_r;
  wire         par_nxt    = ~^fifo_hi_data_i;
  // inbound high byte is checked against its parity pin on capture
  wire         hi_cap     = hs.done && mem16 && !to_mem_i && hs.bv[1];
  wire         perr_set   = hi_cap && (par_s2_r != ~^pb_s2_r);

  // pin synchronisers, two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_s1_r  <= 8'h00;
      pa_s2_r  <= 8'h00;
      pb_s1_r  <= 8'h00;
      pb_s2_r  <= 8'h00;
      par_s1_r <= 1'b0;
      par_s2_r <= 1'b0;
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
    end else begin
      pa_s1_r  <= port_a_i;
      pa_s2_r  <= pa_s1_r;
      pb_s1_r  <= port_b_i;
      pb_s2_r  <= pb_s1_r;
      par_s1_r <= hi_parity_i;
      par_s2_r <= par_s1_r;
      ack_s1_r <= buffer_ack_n_i;
      ack_s2_r <= ack_s1_r;
    end
  end

  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r                   <= gp_cfg_pkg::CFG_RST;
      first_port_output_reg_r <= gp_cfg_pkg::BYTE_RST;
      pb_out_r                <= gp_cfg_pkg::BYTE_RST;
      diff_ctrl_r             <= gp_cfg_pkg::BYTE_RST;
      bv_ctrl_r               <= gp_cfg_pkg::BV_RST;
    end else begin
      if (wr_cfg) cfg_r <= wb_dat_i[gp_cfg_pkg::CFG_W-1:0];
      // odd start clears itself after the first handshake completes; a fresh write wins
      else if (hs.done) cfg_r[gp_cfg_pkg::CFG_ODD] <= 1'b0;
      if (wr_pa) first_port_output_reg_r <= wb_dat_i[7:0];
      if (wr_pb) pb_out_r <= wb_dat_i[7:0];
      if (wr_diff) diff_ctrl_r <= wb_dat_i[7:0];
      if (wr_bv) bv_ctrl_r <= wb_dat_i[1:0];
    end
  end

  // sticky parity error; a new error wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) perr_r <= 1'b0;
    else if (perr_set) perr_r <= 1'b1;
    else if (wr_stat && wb_dat_i[gp_cfg_pkg::ST_PERR]) perr_r <= 1'b0;
  end

  // pin output flops; every pin leaves reset undriven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_o_r   <= 8'hff;
      pa_oe_r  <= 8'h00;
      pb_o_r   <= 8'h00;
      pb_oe_r  <= 8'h00;
      par_o_r  <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      pa_o_r   <= pa_o_nxt;
      pa_oe_r  <= pa_oe_nxt;
      pb_o_r   <= pb_o_nxt;
      pb_oe_r  <= {8{pb_oe_nxt}};
      par_o_r  <= par_nxt;
      par_oe_r <= pb_mem_drv;
    end
  end

  // handshake results toward the fifo side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_pin_r    <= 1'b0;
      xfer_r       <= 1'b0;
      xfer_bytes_r <= 2'h0;
      mem_hi_r     <= 8'h00;
    end else begin
      req_pin_r    <= hs.req;
      xfer_r       <= hs.done;
      xfer_bytes_r <= hs.done ? hs.bv : 2'h0;
      if (hi_cap) mem_hi_r <= pb_s2_r;
    end
  end

  // read mux; unmapped addresses read zero
  wire  [7:0]  pb_rd = (pb_oe && !mem16) ? pb_out_r : pb_s2_r;
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      gp_cfg_pkg::CFG_ADR:    rdat_nxt[gp_cfg_pkg::CFG_W-1:0] = cfg_r;
      gp_cfg_pkg::PA_OUT_ADR: rdat_nxt[7:0] = first_port_output_reg_r;
      gp_cfg_pkg::PA_IN_ADR:  rdat_nxt[7:0] = pa_s2_r;
      gp_cfg_pkg::PB_ADR:     rdat_nxt[7:0] = pb_rd;
      gp_cfg_pkg::DIFF_ADR:   rdat_nxt[7:0] = diff_ctrl_r;
      gp_cfg_pkg::STAT_ADR: begin
        rdat_nxt[gp_cfg_pkg::ST_REQ]  = req_pin_r;
        rdat_nxt[gp_cfg_pkg::ST_BUSY] = hs.busy;
        rdat_nxt[gp_cfg_pkg::ST_PERR] = perr_r;
        rdat_nxt[gp_cfg_pkg::ST_LVL +: 4] = fifo_level_i;
      end
      gp_cfg_pkg::BV_ADR:     rdat_nxt[1:0] = bv_ctrl_r;
      default:                rdat_nxt = 32'h0000_0000;
    endcase
  end

  // single-wait-state ack; drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= wb_req;
      if (wb_req) rdat_r <= rdat_nxt;
    end
  end

  assign wb_dat_o         = rdat_r;
  assign wb_ack_o         = ack_r;
  assign port_a_o         = pa_o_r;
  assign port_a_oe_o      = pa_oe_r;
  assign port_b_o         = pb_o_r;
  assign port_b_oe_o      = pb_oe_r;
  assign hi_parity_o      = par_o_r;
  assign hi_parity_oe_o   = par_oe_r;
  assign buffer_request_o = req_pin_r;
  assign xfer_o           = xfer_r;
  assign xfer_bytes_o     = xfer_bytes_r;
  assign mem_hi_data_o    = mem_hi_r;
endmodule

// [verif/dual_gp_port_config_chk.sv]
`timescale 1ns/10ps
// shadows the mode byte and checks the pins against it
module dual_gp_port_config_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  port_a_o,
  input wire logic [7:0]  port_a_oe_o,
  input wire logic [7:0]  port_b_oe_o,
  input wire logic        hi_parity_o,
  input wire logic        hi_parity_oe_o,
  input wire logic [7:0]  fifo_hi_data_i,
  input wire logic        buffer_request_o,
  input wire logic        to_mem_i,
  input wire logic        last_byte_i,
  input wire logic [3:0]  fifo_level_i
);
  logic [4:0] cfg_r;
  logic [2:0] age_r;
  // taken mode write; the age lets the pin flops catch up first
  wire logic  cfg_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
                       & (wb_adr_i == gp_cfg_pkg::CFG_ADR);
  wire logic  calm   = (age_r == 3'h7);
  wire logic  m16    = calm & cfg_r[3];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= 5'h00;
      age_r <= 3'h7;
    end else if (cfg_wr) begin
      cfg_r <= wb_dat_i[4:0];
      age_r <= 3'h0;
    end else if (!calm) begin
      age_r <= age_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_quiet;
    $fell(rst_i) |-> port_a_oe_o == 8'h00 && port_b_oe_o == 8'h00 && !buffer_request_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pins driven after reset");
  property p_idle;
    calm && cfg_r[3:0] == 4'h0 |-> port_a_oe_o == 8'h00 && port_b_oe_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("port driven while all modes clear");
  property p_gp;
    calm && !cfg_r[1] && !cfg_r[3] |-> port_a_oe_o == {8{cfg_r[0]}} && port_b_oe_o == {8{cfg_r[2]}};
  endproperty
  a_gp: assert property (p_gp) else $error("port enable not following its bit");
  property p_diff;
    calm && cfg_r[1] |-> (port_a_oe_o & 8'h7b) == 8'h7b;
  endproperty
  a_diff: assert property (p_diff) else $error("control lines not driven");
  property p_strb_oe;
    m16 |-> port_a_oe_o[2] && port_a_oe_o[7];
  endproperty
  a_strb_oe: assert property (p_strb_oe) else $error("strobe pins not driven");
  property p_b_mem;
    m16 && buffer_request_o && to_mem_i |-> port_b_oe_o == 8'hff && hi_parity_oe_o;
  endproperty
  a_b_mem: assert property (p_b_mem) else $error("high byte not driven");
  property p_word;
    m16 && !cfg_r[4] && !last_byte_i && buffer_request_o |-> !port_a_o[2] && !port_a_o[7];
  endproperty
  a_word: assert property (p_word) else $error("word strobes not both low");
  property p_wait2;
    $rose(buffer_request_o) && m16 && to_mem_i && !cfg_r[4]
      |-> ($past(fifo_level_i, 2) >= 4'h2) || $past(last_byte_i, 2);
  endproperty
  a_wait2: assert property (p_wait2) else $error("request with under two bytes");
  property p_space;
    $rose(buffer_request_o) |=> (!$rose(buffer_request_o)) [*3];
  endproperty
  a_space: assert property (p_space) else $error("requests closer than four cycles");
  property p_par;
    !$past(rst_i) |-> hi_parity_o == ~^$past(fifo_hi_data_i);
  endproperty
  a_par: assert property (p_par) else $error("high byte parity wrong");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
  c_hs: cover property ($rose(buffer_request_o) && m16);
  c_diff: cover property (calm && cfg_r[1] && cfg_r[3]);
  c_gp: cover property (calm && cfg_r[3:0] == 4'h5);
endmodule

bind dual_gp_port_config dual_gp_port_config_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .port_a_o, .port_a_oe_o, .port_b_oe_o, .hi_parity_o,
  .hi_parity_oe_o, .fifo_hi_data_i, .buffer_request_o, .to_mem_i, .last_byte_i, .fifo_level_i);

// [verif/mem_partner.sv]
`timescale 1ns/10ps
// buffer memory side: acknowledges a request after a chosen stall
module mem_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [2:0] dly_i,
  output logic            ack_n_o
);
  logic [2:0] cnt_r;
  // ack held low until the request drops, so its width never falls short
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      cnt_r   <= 3'h0;
      ack_n_o <= 1'b1;
    end else if (cnt_r == dly_i) begin
      ack_n_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule

// [verif/tb_dual_gp_port_config.sv]
`timescale 1ns/10ps
// self-checking bench for the two-port mode logic
module tb_dual_gp_port_config;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, fifo_hi_data_i = 8'h00, ext_a = 8'h00, ext_b = 8'h00, v, nv;
  logic [3:0]  wb_sel_i = 4'h0, fifo_level_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        dma_active_i = 1'b0, to_mem_i = 1'b0, last_byte_i = 1'b0;
  logic [2:0]  dly = 3'h0;
  logic [7:0]  port_a_i, port_a_o, port_a_oe_o, port_b_i, port_b_o, port_b_oe_o, mem_hi_data_o;
  logic        wb_ack_o, hi_parity_i, hi_parity_o, hi_parity_oe_o, buffer_request_o, buffer_ack_n_i, xfer_o;
  logic [1:0]  xfer_bytes_o;
  logic [4:0]  c;
  int          error_cnt = 0, checked = 0, cyc_cnt = 0;
  // pin levels resolved from both drivers
  assign port_a_i    = (port_a_oe_o & port_a_o) | (~port_a_oe_o & ext_a);
  assign port_b_i    = (port_b_oe_o & port_b_o) | (~port_b_oe_o & ext_b);
  assign hi_parity_i = hi_parity_oe_o ? hi_parity_o : ~^ext_b;
  dual_gp_port_config uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .port_a_i, .port_a_o, .port_a_oe_o, .port_b_i, .port_b_o, .port_b_oe_o,
    .hi_parity_i, .hi_parity_o, .hi_parity_oe_o, .buffer_request_o, .buffer_ack_n_i, .dma_active_i,
    .to_mem_i, .last_byte_i, .fifo_level_i, .fifo_hi_data_i, .xfer_o, .xfer_bytes_o, .mem_hi_data_o);
  mem_partner mem (.clk_i, .rst_i, .req_i(buffer_request_o), .dly_i(dly), .ack_n_o(buffer_ack_n_i));
  always #12.5 clk_i = ~clk_i;
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    // only the run-wide cycle ceiling ends a stuck wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one buffer handshake, then the dma side goes quiet
  task automatic hs(input logic tm, input logic lb, input logic [3:0] lv, input logic [1:0] eb);
    to_mem_i     <= tm;
    last_byte_i  <= lb;
    fifo_level_i <= lv;
    dly          <= 3'($urandom % 6);
    dma_active_i <= 1'b1;
    @(posedge clk_i);
    while (xfer_o !== 1'b1) begin
      @(posedge clk_i);
    end
    chk(xfer_bytes_o, eb);
    if (!tm && eb[1]) chk(mem_hi_data_o, ext_b);
    dma_active_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic [7:0] exp_a_oe(input logic [3:0] m);
    return {m[3] | m[0], {4{m[1] | m[0]}}, m[3] | m[0], {2{m[1] | m[0]}}};
  endfunction
  // parity source churns every cycle; memory holds its high byte while handshakes are allowed
  always @(posedge clk_i) begin
    fifo_hi_data_i <= 8'($urandom);
    if (!dma_active_i) ext_b <= 8'($urandom);
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h4c131f94));
    ext_a = 8'($urandom);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(port_a_oe_o, 8'h00);
    chk(port_b_oe_o, 8'h00);
    for (c = 5'h00; c < 5'h10; c++) begin
      wb(1'b1, gp_cfg_pkg::CFG_ADR, {27'h0, c});
      repeat (4) @(posedge clk_i);
      chk(port_a_oe_o, exp_a_oe(c[3:0]));
      chk(port_b_oe_o, {8{c[2] & ~c[3]}});
    end
    wb(1'b1, gp_cfg_pkg::CFG_ADR, 32'h5);
    repeat (4) begin
      v  = 8'($urandom);
      nv = ~v;
      wb(1'b1, gp_cfg_pkg::PA_OUT_ADR, {24'h0, v});
      wb(1'b1, gp_cfg_pkg::PB_ADR, {24'h0, nv});
      repeat (4) @(posedge clk_i);
      chk(port_a_o, nv);
      chk(port_b_o, nv);
      wb(1'b0, gp_cfg_pkg::PA_IN_ADR, 32'h0);
      chk(rd, {24'h0, nv});
      wb(1'b0, gp_cfg_pkg::PB_ADR, 32'h0);
      chk(rd, {24'h0, nv});
    end
    wb(1'b1, gp_cfg_pkg::CFG_ADR, 32'h2);
    wb(1'b1, gp_cfg_pkg::DIFF_ADR, {24'h0, v});
    repeat (4) @(posedge clk_i);
    chk(port_a_o & 8'h7b, nv & 8'h7b);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, gp_cfg_pkg::CFG_ADR, 32'hc);
    to_mem_i     <= 1'b1;
    fifo_level_i <= 4'h1;
    dma_active_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk(buffer_request_o, 1'b0);
    repeat (6) hs(1'($urandom), 1'b0, 4'h2 + 4'($urandom % 5), 2'b11);
    hs(1'b1, 1'b1, 4'h1, 2'b01);
    wb(1'b1, gp_cfg_pkg::CFG_ADR, 32'h1c);
    hs(1'b0, 1'b0, 4'h5, 2'b10);
    wb(1'b1, gp_cfg_pkg::CFG_ADR, 32'h4);
    hs(1'b0, 1'b0, 4'h0, 2'b01);
    complete_run();
  end
endmodule
